// ==== usc_pkg.sv ====
/*
 * constants and state codes shared by the serial port clock generator,
 * frame engine and its register slave.
 * assumes a single 100 MHz system clock and a 32-bit bus with byte addresses.
 */
package usc_pkg;
   // register byte addresses, low eight address bits decoded
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DIVL = 8'h04;
   localparam logic [7:0] ADDR_DIVH = 8'h08;
   localparam logic [7:0] ADDR_TXDATA = 8'h0c;
   localparam logic [7:0] ADDR_RXDATA = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // control register field positions
   localparam int CB_SYNC = 0;
   localparam int CB_DSPEED = 1;
   localparam int CB_CLKDIR = 2;
   localparam int CB_POL = 3;
   localparam int CB_CSIZE = 4;
   localparam int CB_PARITY = 7;
   localparam int CB_STOP = 9;
   localparam int CB_NINTH = 10;

   // values after reset: 8 data bits, no parity, one stop bit
   localparam logic [10:0] CTRL_RESET = 11'h030;
   localparam logic [11:0] DIV_RESET = 12'h000;

   // baud tick counts per bit and start bit mid points, written as last state index
   localparam logic [3:0] OS_NORMAL_LAST = 4'hf;
   localparam logic [3:0] OS_DOUBLE_LAST = 4'h7;
   localparam logic [3:0] OS_SYNC_LAST = 4'h0;
   localparam logic [3:0] MID_NORMAL = 4'h7;
   localparam logic [3:0] MID_DOUBLE = 4'h3;

   // character size coding
   localparam logic [2:0] CSIZE_NINE = 3'h7;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [1:0] STOPS_ONE = 2'h1;
   localparam logic [1:0] STOPS_TWO = 2'h2;

   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_DATA = 4'b0010,
      TX_PAR = 4'b0100,
      TX_STOP = 4'b1000
   } usc_tx_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001,
      RX_START = 5'b00010,
      RX_DATA = 5'b00100,
      RX_PAR = 5'b01000,
      RX_STOP = 5'b10000
   } usc_rx_t;
endpackage

// ==== usc_baud_gen.sv ====
/*
 * baud rate generator: a 12-bit down-counter on the system clock.
 * assumes reload is a one-cycle pulse that comes with the new divisor.
 */
`timescale 1ns/1ns
module usc_baud_gen (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [11:0] divisor,
   input wire logic reload,
   output logic baudTick
);
   typedef struct packed {
      logic [11:0] cnt;
   } usc_baud_t;

   usc_baud_t s_reg;
   usc_baud_t s_next;

   // one tick per pass through zero
   assign baudTick = (s_reg.cnt == 12'h000);

   // count down, reload at zero or on a low-byte write
   always_comb begin
      s_next = s_reg;
      if (reload || baudTick) begin
         s_next.cnt = divisor;
      end else begin
         s_next.cnt = s_reg.cnt - 12'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_reg.cnt <= usc_pkg::DIV_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   property p_reload_value;
      baudTick || reload |=> s_reg.cnt == $past(divisor);
   endproperty
   a_reload_value: assert property (p_reload_value) else $error("counter missed reload");

   property p_count_down;
      !baudTick && !reload |=> s_reg.cnt == $past(s_reg.cnt) - 12'h001
         && baudTick == ($past(s_reg.cnt) == 12'h001);
   endproperty
   a_count_down: assert property (p_count_down) else $error("counter did not step");
endmodule

// ==== usc_core.sv ====
/*
 * serial port clock generation and frame engine with an AHB-Lite register slave.
 * assumes serial pin already sampled to clk_sys, clock pin synchronised here; one slave on the bus.
 */
`timescale 1ns/1ns
module usc_core (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic serialInPin,
   output logic serialOutPin,
   input wire logic transferClockPinIn,
   output logic transferClockPinOut,
   output logic transferClockPinOe
);
   typedef struct packed {
      logic [10:0] ctrl;
      logic [3:0] divHigh;
      logic [11:0] divisor;
      logic aPend;
      logic aWrite;
      logic [7:0] aAddr;
      logic [31:0] rdata;
      logic [2:0] xSync;
      logic xckOut;
      logic [3:0] txPre;
      usc_pkg::usc_tx_t txState;
      logic [8:0] txBuf;
      logic txBufValid;
      logic [8:0] txShift;
      logic [3:0] txIdx;
      logic [1:0] txStops;
      logic txPar;
      logic txLine;
      usc_pkg::usc_rx_t rxState;
      logic [3:0] rxCnt;
      logic [3:0] rxIdx;
      logic [8:0] rxShift;
      logic rxPar;
      logic rxParBad;
      logic [8:0] rxData;
      logic txDone;
      logic rxDone;
      logic frameErr;
      logic parErr;
   } usc_state_t;

   usc_state_t s_reg;
   usc_state_t s_next;

   logic syncMode, doubleSpeed, masterMode, slaveMode, polarity;
   logic [2:0] charSize;
   logic [3:0] nBits, lastData, osLast, rxLast, rxMid;
   logic parEn, oddSel;
   logic [1:0] stops;
   logic baudTick, divLoad;
   logic [11:0] genDiv;
   logic rawRise, rawFall, clkRise, clkFall, changeEdge, sampleEdge;
   logic txStep, rxTick, addrPhase;
   logic startNew, rxSample, txClr, rxClr;

   // mode decode from the control register
   assign syncMode = s_reg.ctrl[usc_pkg::CB_SYNC];
   assign doubleSpeed = s_reg.ctrl[usc_pkg::CB_DSPEED] & ~syncMode;
   assign masterMode = syncMode & s_reg.ctrl[usc_pkg::CB_CLKDIR];
   assign slaveMode = syncMode & ~s_reg.ctrl[usc_pkg::CB_CLKDIR];
   assign polarity = s_reg.ctrl[usc_pkg::CB_POL];

   // frame format shared by transmitter and receiver; stop count used by the transmitter only
   assign charSize = s_reg.ctrl[usc_pkg::CB_CSIZE +: 3];
   assign nBits = (charSize == usc_pkg::CSIZE_NINE) ? usc_pkg::BITS_NINE :
                  charSize[2] ? usc_pkg::BITS_EIGHT : ({2'b01, charSize[1:0]} + 4'h1);
   assign lastData = nBits - 4'h1;
   assign parEn = s_reg.ctrl[usc_pkg::CB_PARITY + 1];
   assign oddSel = s_reg.ctrl[usc_pkg::CB_PARITY];
   assign stops = s_reg.ctrl[usc_pkg::CB_STOP] ? usc_pkg::STOPS_TWO : usc_pkg::STOPS_ONE;

   // a low-byte write hands the whole divisor to the counter at once
   assign divLoad = s_reg.aPend & s_reg.aWrite & (s_reg.aAddr == usc_pkg::ADDR_DIVL);
   assign genDiv = divLoad ? {s_reg.divHigh, hwdata[7:0]} : s_reg.divisor;

   usc_baud_gen baudGen (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .divisor(genDiv),
      .reload(divLoad),
      .baudTick(baudTick)
   );

   // transfer clock edges: own toggle in master, synchronised pin in slave
   assign rawRise = s_reg.xSync[1] & ~s_reg.xSync[2];
   assign rawFall = ~s_reg.xSync[1] & s_reg.xSync[2];
   assign clkRise = (masterMode & baudTick & ~s_reg.xckOut) | (slaveMode & rawRise);
   assign clkFall = (masterMode & baudTick & s_reg.xckOut) | (slaveMode & rawFall);
   assign changeEdge = polarity ? clkFall : clkRise;
   assign sampleEdge = polarity ? clkRise : clkFall;

   // bit pacing per mode
   assign osLast = doubleSpeed ? usc_pkg::OS_DOUBLE_LAST : usc_pkg::OS_NORMAL_LAST;
   assign rxLast = syncMode ? usc_pkg::OS_SYNC_LAST : osLast;
   assign rxMid = doubleSpeed ? usc_pkg::MID_DOUBLE : usc_pkg::MID_NORMAL;
   assign txStep = syncMode ? changeEdge : (baudTick & (s_reg.txPre == osLast));
   assign rxTick = syncMode ? sampleEdge : baudTick;

   // zero-wait slave, always OKAY
   assign addrPhase = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign serialOutPin = s_reg.txLine;
   assign transferClockPinOut = s_reg.xckOut;
   assign transferClockPinOe = masterMode;

   // next state: bus, clock edges, transmitter, receiver
   always_comb begin
      s_next = s_reg;
      startNew = 1'b0;
      rxSample = 1'b0;
      txClr = 1'b0;
      rxClr = 1'b0;

      // data phase of a write
      if (s_reg.aPend && s_reg.aWrite) begin
         case (s_reg.aAddr)
            usc_pkg::ADDR_CTRL: begin
               s_next.ctrl = hwdata[10:0];
            end
            usc_pkg::ADDR_DIVH: begin
               s_next.divHigh = hwdata[3:0];
            end
            usc_pkg::ADDR_DIVL: begin
               s_next.divisor = genDiv;
            end
            usc_pkg::ADDR_STATUS: begin
               txClr = hwdata[0];
            end
            default: begin
            end
         endcase
      end

      // address phase; read data registered for the data phase
      s_next.aPend = addrPhase;
      if (addrPhase) begin
         s_next.aWrite = hwrite;
         s_next.aAddr = haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
         case (haddr[7:0])
            usc_pkg::ADDR_CTRL: s_next.rdata = {21'h000000, s_reg.ctrl};
            usc_pkg::ADDR_DIVL: s_next.rdata = {24'h000000, s_reg.divisor[7:0]};
            usc_pkg::ADDR_DIVH: s_next.rdata = {28'h0000000, s_reg.divHigh};
            usc_pkg::ADDR_RXDATA: begin
               s_next.rdata = {23'h000000, s_reg.rxData};
               rxClr = 1'b1;
            end
            usc_pkg::ADDR_STATUS: begin
               s_next.rdata = {26'h0000000, s_reg.txState != usc_pkg::TX_IDLE, ~s_reg.txBufValid,
                               s_reg.parErr, s_reg.frameErr, s_reg.rxDone, s_reg.txDone};
            end
            default: s_next.rdata = 32'h00000000;
         endcase
      end
      if (txClr) begin
         s_next.txDone = 1'b0;
      end
      if (rxClr) begin
         s_next.rxDone = 1'b0;
      end

      // pin synchroniser, previous-value stage, master clock toggle
      s_next.xSync = {s_reg.xSync[1], s_reg.xSync[0], transferClockPinIn};
      if (!masterMode) begin
         s_next.xckOut = 1'b0;
      end else if (baudTick) begin
         s_next.xckOut = ~s_reg.xckOut;
      end

      // async transmit prescaler, free running on baud ticks
      if (syncMode) begin
         s_next.txPre = 4'h0;
      end else if (baudTick) begin
         s_next.txPre = (s_reg.txPre == osLast) ? 4'h0 : s_reg.txPre + 4'h1;
      end

      // transmitter, one step per bit time
      if (txStep) begin
         case (s_reg.txState)
            usc_pkg::TX_IDLE: begin
               s_next.txLine = 1'b1;
               startNew = s_reg.txBufValid;
            end
            usc_pkg::TX_DATA: begin
               s_next.txLine = s_reg.txShift[0];
               s_next.txPar = s_reg.txPar ^ s_reg.txShift[0];
               s_next.txShift = {1'b0, s_reg.txShift[8:1]};
               s_next.txIdx = s_reg.txIdx + 4'h1;
               if (s_reg.txIdx == lastData) begin
                  s_next.txStops = 2'h0;
                  s_next.txState = parEn ? usc_pkg::TX_PAR : usc_pkg::TX_STOP;
               end
            end
            usc_pkg::TX_PAR: begin
               s_next.txLine = s_reg.txPar ^ oddSel;
               s_next.txState = usc_pkg::TX_STOP;
            end
            usc_pkg::TX_STOP: begin
               s_next.txLine = 1'b1;
               if (s_reg.txStops == stops) begin
                  startNew = s_reg.txBufValid;
                  if (!s_reg.txBufValid) begin
                     s_next.txDone = 1'b1;
                     s_next.txState = usc_pkg::TX_IDLE;
                  end
               end else begin
                  s_next.txStops = s_reg.txStops + 2'h1;
               end
            end
            default: s_next.txState = usc_pkg::TX_IDLE;
         endcase
      end
      if (startNew) begin
         s_next.txLine = 1'b0;
         s_next.txShift = s_reg.txBuf;
         s_next.txBufValid = 1'b0;
         s_next.txIdx = 4'h0;
         s_next.txPar = 1'b0;
         s_next.txState = usc_pkg::TX_DATA;
      end

      // a data write after the hand-off is kept; ninth bit taken now
      if (s_reg.aPend && s_reg.aWrite && s_reg.aAddr == usc_pkg::ADDR_TXDATA) begin
         s_next.txBuf = {s_reg.ctrl[usc_pkg::CB_NINTH], hwdata[7:0]};
         s_next.txBufValid = 1'b1;
      end

      // receiver state counter, steps on its tick only
      if (rxTick) begin
         case (s_reg.rxState)
            usc_pkg::RX_IDLE: begin
               if (!serialInPin) begin
                  s_next.rxCnt = 4'h0;
                  s_next.rxIdx = 4'h0;
                  s_next.rxPar = 1'b0;
                  s_next.rxParBad = 1'b0;
                  s_next.rxShift = 9'h000;
                  s_next.rxState = syncMode ? usc_pkg::RX_DATA : usc_pkg::RX_START;
               end
            end
            usc_pkg::RX_START: begin
               if (s_reg.rxCnt == rxMid) begin
                  s_next.rxCnt = 4'h0;
                  s_next.rxState = serialInPin ? usc_pkg::RX_IDLE : usc_pkg::RX_DATA;
               end else begin
                  s_next.rxCnt = s_reg.rxCnt + 4'h1;
               end
            end
            usc_pkg::RX_DATA, usc_pkg::RX_PAR, usc_pkg::RX_STOP: begin
               if (s_reg.rxCnt == rxLast) begin
                  s_next.rxCnt = 4'h0;
                  rxSample = 1'b1;
               end else begin
                  s_next.rxCnt = s_reg.rxCnt + 4'h1;
               end
            end
            default: s_next.rxState = usc_pkg::RX_IDLE;
         endcase
      end

      // receiver bit capture
      if (rxSample) begin
         case (s_reg.rxState)
            usc_pkg::RX_DATA: begin
               s_next.rxShift[s_reg.rxIdx] = serialInPin;
               s_next.rxPar = s_reg.rxPar ^ serialInPin;
               s_next.rxIdx = s_reg.rxIdx + 4'h1;
               if (s_reg.rxIdx == lastData) begin
                  s_next.rxState = parEn ? usc_pkg::RX_PAR : usc_pkg::RX_STOP;
               end
            end
            usc_pkg::RX_PAR: begin
               s_next.rxParBad = s_reg.rxPar ^ oddSel ^ serialInPin;
               s_next.rxState = usc_pkg::RX_STOP;
            end
            usc_pkg::RX_STOP: begin
               s_next.frameErr = ~serialInPin;
               s_next.parErr = parEn & s_reg.rxParBad;
               s_next.rxData = s_reg.rxShift;
               s_next.rxDone = 1'b1;
               s_next.rxState = usc_pkg::RX_IDLE;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.ctrl <= usc_pkg::CTRL_RESET;
         s_reg.divisor <= usc_pkg::DIV_RESET;
         s_reg.txState <= usc_pkg::TX_IDLE;
         s_reg.rxState <= usc_pkg::RX_IDLE;
         s_reg.txLine <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   property p_async_pin_idle;
      !syncMode[*2] |-> !transferClockPinOe && !transferClockPinOut;
   endproperty
   a_async_pin_idle: assert property (p_async_pin_idle) else $error("clock pin active outside sync");

   property p_master_toggle;
      masterMode && $past(masterMode) && baudTick |=> transferClockPinOut != $past(transferClockPinOut);
   endproperty
   a_master_toggle: assert property (p_master_toggle) else $error("master clock did not toggle");

   property p_async_bit_rate;
      txStep && !syncMode |-> baudTick && s_reg.txPre == (doubleSpeed ? 4'h7 : 4'hf);
   endproperty
   a_async_bit_rate: assert property (p_async_bit_rate) else $error("bit step off the tick grid");

   property p_start_mid;
      !syncMode && s_reg.rxState == usc_pkg::RX_START && rxTick && !serialInPin
         && s_reg.rxCnt == (doubleSpeed ? 4'h3 : 4'h7) |=> s_reg.rxState == usc_pkg::RX_DATA;
   endproperty
   a_start_mid: assert property (p_start_mid) else $error("start bit not taken at mid point");

   property p_slave_delay;
      (slaveMode && $rose(transferClockPinIn)) ##1 (slaveMode && transferClockPinIn) |-> ##1 rawRise;
   endproperty
   a_slave_delay: assert property (p_slave_delay) else $error("slave edge not seen two cycles on");

   property p_change_edge;
      syncMode && $past(syncMode) && $changed(serialOutPin) |-> $past(changeEdge);
   endproperty
   a_change_edge: assert property (p_change_edge) else $error("data changed off its clock edge");

   property p_start_bit;
      startNew |=> !serialOutPin && s_reg.txState == usc_pkg::TX_DATA && s_reg.txIdx == 4'h0;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("frame did not open with start bit");

   property p_parity_out;
      txStep && s_reg.txState == usc_pkg::TX_PAR |=> serialOutPin == ($past(s_reg.txPar) ^ $past(oddSel));
   endproperty
   a_parity_out: assert property (p_parity_out) else $error("parity bit wrong");

   property p_frame_error;
      rxSample && s_reg.rxState == usc_pkg::RX_STOP |=> s_reg.frameErr == !$past(serialInPin) && s_reg.rxDone;
   endproperty
   a_frame_error: assert property (p_frame_error) else $error("frame error not from first stop");

   property p_high_held;
      s_reg.aPend && s_reg.aWrite && s_reg.aAddr == usc_pkg::ADDR_DIVH |=> $stable(s_reg.divisor);
   endproperty
   a_high_held: assert property (p_high_held) else $error("divisor changed on high byte write");

   c_frame_sent: cover property (startNew ##[1:1000] s_reg.txDone);
   c_frame_received: cover property (rxSample && s_reg.rxState == usc_pkg::RX_STOP);
   c_slave_edge: cover property (slaveMode && rawRise);
endmodule

// ==== usc_peer.sv ====
/* peer serial device: sends async frames on the receive line, makes a slave clock.
   assumes the bench drives its controls just after rising clk_sys edges. */
`timescale 1ns/1ns
module usc_peer (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [15:0] frame,
   input wire logic [4:0] len,
   input wire logic [15:0] bitCycles,
   input wire logic clkRun,
   output logic serialLine,
   output logic slaveClk
);
   logic [15:0] sh;
   logic [15:0] cnt;
   logic [4:0] left = 5'h00;
   logic [2:0] half = 3'h0;
   initial begin
      serialLine = 1'b1;
      slaveClk = 1'b0;
   end
   // frame shifter, line idles high between frames
   always @(posedge clk_sys) begin
      if (go) begin
         sh <= frame;
         left <= len;
         cnt <= 16'h0000;
      end else if (left != 5'h00) begin
         serialLine <= sh[0];
         cnt <= cnt + 16'h0001;
         if (cnt == bitCycles - 16'h0001) begin
            sh <= sh >> 1;
            left <= left - 5'h01;
            cnt <= 16'h0000;
         end
      end else begin
         serialLine <= 1'b1;
      end
   end
   // slave clock: half period of 6 cycles, still when not running
   always @(posedge clk_sys) begin
      half <= (clkRun && half != 3'h5) ? half + 3'h1 : 3'h0;
      if (!clkRun) slaveClk <= 1'b0;
      else if (half == 3'h5) slaveClk <= ~slaveClk;
   end
endmodule

// ==== usc_core_tb.sv ====
/* bench for usc_core: bus tasks, tx frame capture, rx through the peer model.
   assumes a 100 MHz clk_sys and a zero-wait bus slave. */
`timescale 1ns/1ns
module usc_core_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic go = 1'b0;
   logic clkRun = 1'b0;
   logic [15:0] frame = 16'hffff;
   logic [15:0] bitCycles = 16'h0020;
   wire logic hreadyout, hresp, serialOutPin, clkOut, clkOe, serialInPin, peerClk;
   wire logic [31:0] hrdata;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   // clock pin level from both drivers
   wire logic clkIn = clkOe ? clkOut : peerClk;
   usc_core dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
      .transferClockPinIn(clkIn), .transferClockPinOut(clkOut), .transferClockPinOe(clkOe));
   usc_peer peer_u (.clk_sys(clk_sys), .go(go), .frame(frame), .len(5'h0b), .bitCycles(bitCycles),
      .clkRun(clkRun), .serialLine(serialInPin), .slaveClk(peerClk));
   always #5 clk_sys = ~clk_sys;
   // cut a hang short
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         failures++;
         tally_and_finish();
      end
   end
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // single bus transfer: address phase, then data phase
   task xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task rd(logic [7:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask
   // expected frame, lsb first: start, data, parity, stops high
   function automatic logic [15:0] mk(logic [8:0] d, int n, logic pe, logic od);
      logic [15:0] f;
      f = 16'hffff;
      f[0] = 1'b0;
      for (int i = 0; i < n; i++) f[i + 1] = d[i];
      if (pe) f[n + 1] = ^(d & ((9'h1 << n) - 9'h1)) ^ od;
      return f;
   endfunction
   // length of the next stretch at level v of tx line or clock pin
   task span(bit ck, logic v, output int k);
      k = 0;
      while ((ck ? clkOut : serialOutPin) !== v && k < 9000) begin
         @(negedge clk_sys);
         k++;
      end
      k = 0;
      while ((ck ? clkOut : serialOutPin) === v && k < 9000) begin
         @(negedge clk_sys);
         k++;
      end
   endtask
   task txf(logic [7:0] d, logic [15:0] fr, int n, int bc);
      int k;
      wr(usc_pkg::ADDR_TXDATA, {24'h0, d});
      k = 0;
      while (serialOutPin !== 1'b0 && k < 4 * bc) begin
         @(negedge clk_sys);
         k++;
      end
      repeat (bc / 2) @(negedge clk_sys);
      for (int i = 0; i < n; i++) begin
         chk("txbit", serialOutPin, fr[i]);
         repeat (bc) @(negedge clk_sys);
      end
      chk("idle", serialOutPin, 1'b1);
      @(posedge clk_sys);
   endtask
   task t_reset();
      logic [31:0] v;
      chk("txreset", serialOutPin, 1'b1);
      chk("oereset", clkOe, 1'b0);
      chk("okay", hresp, 1'b0);
      rd(usc_pkg::ADDR_CTRL, v);
      chk("ctrlreset", v, {21'h0, usc_pkg::CTRL_RESET});
      rd(8'h40, v);
      chk("unmapped", v, 32'h0);
      $display("test reset done");
   endtask
   // formats: 8n1, 5e2, 7o1, 9e2 with ninth bit, reserved parity code
   task automatic t_formats();
      logic [10:0] c [5] = '{11'h030, 11'h300, 11'h1a0, 11'h770, 11'h0b0};
      logic [8:0] d [5] = '{9'h0a5, 9'h01d, 9'h035, 9'h15a, 9'h0a5};
      int n [5] = '{8, 5, 7, 9, 8};
      wr(usc_pkg::ADDR_DIVH, 32'h0);
      wr(usc_pkg::ADDR_DIVL, 32'h1);
      for (int i = 0; i < 5; i++) begin
         wr(usc_pkg::ADDR_CTRL, {21'h0, c[i]});
         txf(d[i][7:0], mk(d[i], n[i], c[i][8], c[i][7]), n[i] + 2 + c[i][8] + c[i][9], 32);
      end
      chk("oeasync", clkOe, 1'b0);
      $display("test formats done");
   endtask
   // start bit length with data bit 0 high
   task rate(logic [10:0] c, logic [11:0] dv, int bc);
      int k;
      wr(usc_pkg::ADDR_CTRL, {21'h0, c});
      wr(usc_pkg::ADDR_DIVH, {28'h0, dv[11:8]});
      wr(usc_pkg::ADDR_DIVL, {24'h0, dv[7:0]});
      wr(usc_pkg::ADDR_TXDATA, 32'h1);
      span(1'b0, 1'b0, k);
      chk("bitlen", k, bc);
      repeat (10 * bc) @(posedge clk_sys);
      $display("test rate done");
   endtask
   task t_master();
      int k;
      // clear the staged high bits left by the slow rate test
      wr(usc_pkg::ADDR_DIVH, 32'h0);
      wr(usc_pkg::ADDR_DIVL, 32'h3);
      wr(usc_pkg::ADDR_CTRL, 32'h035);
      @(negedge clk_sys);
      chk("oemaster", clkOe, 1'b1);
      span(1'b1, 1'b1, k);
      chk("clkhigh", k, 4);
      @(posedge clk_sys);
      $display("test master done");
   endtask
   task rxf(logic [15:0] fr, int bc, logic fe);
      logic [31:0] v;
      int k;
      bitCycles <= bc[15:0];
      frame <= fr;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      k = 0;
      do begin
         rd(usc_pkg::ADDR_STATUS, v);
         k++;
      end while (v[1] !== 1'b1 && k < 500);
      chk("frameerr", v[2], fe);
      rd(usc_pkg::ADDR_RXDATA, v);
      chk("rxdata", v, 32'h3c);
      repeat (bc) @(posedge clk_sys);
      // a low second stop reads as a new start bit; let that frame end and drop it
      repeat (11 * bc) @(posedge clk_sys);
      rd(usc_pkg::ADDR_RXDATA, v);
   endtask
   task t_rx();
      wr(usc_pkg::ADDR_DIVL, 32'h1);
      wr(usc_pkg::ADDR_CTRL, 32'h230);
      rxf(mk(9'h03c, 8, 1'b0, 1'b0) & 16'hfdff, 32, 1'b1);
      rxf(mk(9'h03c, 8, 1'b0, 1'b0) & 16'hfbff, 32, 1'b0);
      wr(usc_pkg::ADDR_CTRL, 32'h232);
      rxf(mk(9'h03c, 8, 1'b0, 1'b0), 16, 1'b0);
      $display("test rx done");
   endtask
   // slave mode: tx line changes only in the clock half after the change edge
   task t_slave();
      logic prev;
      int n;
      for (int p = 0; p < 2; p++) begin
         wr(usc_pkg::ADDR_CTRL, 32'h031 | (p << 3));
         wr(usc_pkg::ADDR_TXDATA, 32'h5a);
         chk("oeslave", clkOe, 1'b0);
         clkRun <= 1'b1;
         n = 0;
         prev = serialOutPin;
         repeat (200) begin
            @(negedge clk_sys);
            if (serialOutPin !== prev) begin
               n++;
               chk("chgedge", clkIn, p == 0);
            end
            prev = serialOutPin;
         end
         chk("changes", n > 3, 1'b1);
         @(posedge clk_sys);
         clkRun <= 1'b0;
         repeat (20) @(posedge clk_sys);
      end
      $display("test slave done");
   endtask
   task tally_and_finish();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_formats();
      rate(11'h030, 12'h002, 48);
      rate(11'h032, 12'h002, 24);
      rate(11'h032, 12'h103, 2080);
      t_master();
      t_rx();
      t_slave();
      tally_and_finish();
   end
endmodule
